// File: rtl/mtc_timer.sv
// Purpose: Multimode 16-bit timer/counter with Avalon-MM registers
// Assumes: CLK_SYS_IN is high_freq_clock; LOW_FREQ_TICK_IN pulses once
//          per low_freq_clock period
// Notes:   Registers A and B keep their contents through reset
//
// Implementation choices: the Avalon-MM register port and the register addresses.
module mtc_timer (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [4:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        PULSE_INPUT_PIN_IN,
  input  wire logic        LOW_FREQ_TICK_IN,
  output logic             PULSE_GENERATOR_OUTPUT_OUT,
  output logic             TIMER_MATCH_INTERRUPT_OUT
);
  // ******************************
  // Declarations
  // ******************************
  logic [mtc_pkg::CTRL_W-1:0]  ctrl_reg;
  logic [mtc_pkg::CFG_W-1:0]   cfg_reg;
  logic [15:0]                 cmp_a_reg;
  logic [15:0]                 cap_b_reg;
  logic [15:0]                 count_reg;
  logic [mtc_pkg::PRE_W-1:0]   pre_reg;
  logic [mtc_pkg::FS_SH_8-1:0] fs_pre_reg;
  logic                        ff_reg;
  logic                        irq_reg;
  logic                        ack_reg;
  logic [31:0]                 rdata_reg;
  mtc_pkg::mtc_state_t         state_reg;
  mtc_pkg::mtc_state_t         state_next;

  logic [mtc_pkg::MODE_W-1:0]  mode;
  logic [mtc_pkg::CKSEL_W-1:0] cksel;
  logic                        edge_sel;
  logic                        slow;
  logic                        wr_go;
  logic                        rd_go;
  logic                        wr_ctrl;
  logic                        tick_fc8;
  logic                        tick_fc128;
  logic                        tick_fc2k;
  logic                        tick_fs8;
  logic                        int_tick;
  logic                        start_edge;
  logic                        stop_edge;
  logic                        adv;
  logic                        match_a;
  logic                        match_b;
  logic                        sw_cap;
  logic                        pw_cap;
  logic                        cap_en;
  logic                        clr_cnt;

  mtc_edge_if edge_if ();

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) r[7:0]  = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_a);
    return a == reg_a;
  endfunction

  assign mode     = ctrl_reg[mtc_pkg::MODE_LSB +: mtc_pkg::MODE_W];
  assign cksel    = ctrl_reg[mtc_pkg::CKSEL_LSB +: mtc_pkg::CKSEL_W];
  assign edge_sel = cfg_reg[mtc_pkg::CFG_EDGE_BIT];
  assign slow     = cfg_reg[mtc_pkg::CFG_SLOW_BIT];
  assign edge_if.slow_mode = slow;

  // ******************************
  // Pulse input conditioning
  // ******************************
  mtc_input_filter #(
    .FLEN (mtc_pkg::FILT_LEN)
  ) u_filter (
    .clk_in   (CLK_SYS_IN),
    .rst_b_in (RST_B_IN),
    .pin_in   (PULSE_INPUT_PIN_IN),
    .edge_if  (edge_if)
  );

  // Input edge select shared with the window-mode count polarity
  assign start_edge = edge_sel ? edge_if.fall : edge_if.rise;
  assign stop_edge  = edge_sel ? edge_if.rise : edge_if.fall;

  // ******************************
  // Avalon-MM slave: one wait cycle per access
  // ******************************
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_reg;
  assign wr_go   = AVS_WRITE_IN & ack_reg;
  assign rd_go   = AVS_READ_IN & ~ack_reg;
  assign wr_ctrl = wr_go & hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CTRL) & AVS_BYTEENABLE_IN[0];

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack_reg;
    end
  end

  // Read data latched one edge early so it is steady when waitrequest drops
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_reg <= 32'h0000_0000;
      if (hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CTRL)) begin
        rdata_reg[mtc_pkg::CTRL_W-1:0] <= ctrl_reg;
      end else if (hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CMP_A)) begin
        rdata_reg[15:0] <= cmp_a_reg;
      end else if (hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CAP_B)) begin
        rdata_reg[15:0] <= cap_b_reg;
      end else if (hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_COUNT)) begin
        rdata_reg[15:0] <= count_reg;
      end else if (hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CFG)) begin
        rdata_reg[mtc_pkg::CFG_W-1:0] <= cfg_reg;
      end else if (hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_STATUS)) begin
        rdata_reg[mtc_pkg::ST_RUN_BIT]  <= state_reg == mtc_pkg::ST_RUN;
        rdata_reg[mtc_pkg::ST_WAIT_BIT] <= state_reg == mtc_pkg::ST_WAIT;
        rdata_reg[mtc_pkg::ST_FF_BIT]   <= ff_reg;
        rdata_reg[mtc_pkg::ST_PIN_BIT]  <= edge_if.level;
      end
    end
  end
  assign AVS_READDATA_OUT = rdata_reg;

  // ******************************
  // Control and config registers
  // ******************************
  // Capture request is cleared by hardware only in modes that use it
  // as software capture; in pulse width mode it selects capture type
  assign sw_cap = ctrl_reg[mtc_pkg::CAP_BIT] &
                  (mode == mtc_pkg::MODE_TIMER || mode == mtc_pkg::MODE_EVENT ||
                   mode == mtc_pkg::MODE_WINDOW);

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_reg <= mtc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= AVS_WRITEDATA_IN[mtc_pkg::CTRL_W-1:0];
    end else if (sw_cap) begin
      ctrl_reg[mtc_pkg::CAP_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cfg_reg <= mtc_pkg::CFG_RESET;
    end else if (wr_go && hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CFG) && AVS_BYTEENABLE_IN[0]) begin
      cfg_reg <= AVS_WRITEDATA_IN[mtc_pkg::CFG_W-1:0];
    end
  end

  // No reset: contents survive a system reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_go && hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CMP_A)) begin
      cmp_a_reg <= merge16(cmp_a_reg, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end
  end

  // ******************************
  // Count clock prescaler
  // ******************************
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pre_reg    <= '0;
      fs_pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      if (LOW_FREQ_TICK_IN) begin
        fs_pre_reg <= fs_pre_reg + 1'b1;
      end
    end
  end

  assign tick_fc8   = &pre_reg[mtc_pkg::FC_SH_8-1:0];
  assign tick_fc128 = &pre_reg[mtc_pkg::FC_SH_128-1:0];
  assign tick_fc2k  = &pre_reg[mtc_pkg::FC_SH_2K-1:0];
  assign tick_fs8   = LOW_FREQ_TICK_IN & (&fs_pre_reg);

  // Slow modes have no high_freq_clock, so only fs/8 is offered
  always_comb begin
    int_tick = tick_fs8;
    if (!slow) begin
      case (cksel)
        mtc_pkg::CK_DIV8:   int_tick = tick_fc8;
        mtc_pkg::CK_DIV128: int_tick = tick_fc128;
        mtc_pkg::CK_DIV2K:  int_tick = cfg_reg[mtc_pkg::CFG_DIVSRC_BIT] ? tick_fs8 : tick_fc2k;
        default:            int_tick = tick_fs8;
      endcase
    end
  end

  // ******************************
  // Run control
  // ******************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mtc_pkg::ST_STOP: begin
        state_next = mtc_pkg::ST_STOP;
      end
      mtc_pkg::ST_WAIT: begin
        if (start_edge) begin
          state_next = mtc_pkg::ST_RUN;
        end
      end
      mtc_pkg::ST_RUN: begin
        if (mode == mtc_pkg::MODE_EXTTRG && adv && match_a) begin
          state_next = mtc_pkg::ST_WAIT;
        end else if (mode == mtc_pkg::MODE_PWM && stop_edge && !ctrl_reg[mtc_pkg::CAP_BIT]) begin
          state_next = mtc_pkg::ST_WAIT;
        end
      end
      default: begin
        state_next = mtc_pkg::ST_STOP;
      end
    endcase
    if (wr_ctrl) begin
      if (!AVS_WRITEDATA_IN[mtc_pkg::START_BIT]) begin
        state_next = mtc_pkg::ST_STOP;
      end else if (AVS_WRITEDATA_IN[mtc_pkg::MODE_LSB +: mtc_pkg::MODE_W] == mtc_pkg::MODE_EXTTRG ||
                   AVS_WRITEDATA_IN[mtc_pkg::MODE_LSB +: mtc_pkg::MODE_W] == mtc_pkg::MODE_PWM ||
                   (AVS_WRITEDATA_IN[mtc_pkg::MODE_LSB +: mtc_pkg::MODE_W] == mtc_pkg::MODE_PPG &&
                    cfg_reg[mtc_pkg::CFG_PPG_EDGE_BIT])) begin
        if (state_reg == mtc_pkg::ST_STOP) state_next = mtc_pkg::ST_WAIT;
      end else if (state_reg == mtc_pkg::ST_STOP) begin
        state_next = mtc_pkg::ST_RUN;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg <= mtc_pkg::ST_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // ******************************
  // Up-counter
  // ******************************
  always_comb begin
    case (mode)
      mtc_pkg::MODE_EVENT:  adv = start_edge;
      mtc_pkg::MODE_WINDOW: adv = int_tick & (edge_if.level ^ edge_sel);
      default:              adv = int_tick;
    endcase
    adv = adv & (state_reg == mtc_pkg::ST_RUN);
  end

  assign match_a = count_reg == cmp_a_reg;
  assign match_b = count_reg == cap_b_reg;
  assign pw_cap  = mode == mtc_pkg::MODE_PWM && state_reg == mtc_pkg::ST_RUN &&
                   (stop_edge || (start_edge && ctrl_reg[mtc_pkg::CAP_BIT]));
  assign clr_cnt = adv && match_a && mode != mtc_pkg::MODE_PWM;

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      count_reg <= 16'h0000;
    end else if (state_reg == mtc_pkg::ST_WAIT || clr_cnt) begin
      count_reg <= 16'h0000;
    end else if (mode == mtc_pkg::MODE_PWM && stop_edge && !ctrl_reg[mtc_pkg::CAP_BIT]) begin
      count_reg <= 16'h0000;
    end else if (adv) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ******************************
  // Register B: capture or pulse compare
  // ******************************
  assign cap_en = sw_cap | pw_cap;

  // No reset: contents survive a system reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (cap_en) begin
      cap_b_reg <= count_reg;
    end else if (wr_go && hit(AVS_ADDRESS_IN, mtc_pkg::ADDR_CAP_B) && mode == mtc_pkg::MODE_PPG) begin
      cap_b_reg <= merge16(cap_b_reg, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end
  end

  // ******************************
  // Output flip-flop and match interrupt
  // ******************************
  // Preset only by a control write that clears START, so a running pulse train is never disturbed
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ff_reg <= 1'b0;
    end else if (wr_ctrl && !AVS_WRITEDATA_IN[mtc_pkg::START_BIT]) begin
      ff_reg <= AVS_WRITEDATA_IN[mtc_pkg::FF_BIT];
    end else if (mode == mtc_pkg::MODE_PPG && adv && (match_a || match_b)) begin
      ff_reg <= ~ff_reg;
    end
  end
  assign PULSE_GENERATOR_OUTPUT_OUT = ff_reg;

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= clr_cnt || (mode == mtc_pkg::MODE_PWM && state_reg == mtc_pkg::ST_RUN && stop_edge);
    end
  end
  assign TIMER_MATCH_INTERRUPT_OUT = irq_reg;
endmodule // mtc_timer

// File: rtl/mtc_pkg.sv
// Purpose: Constants for the multimode 16-bit timer/counter
// Assumes: 32-bit Avalon-MM words, byte addresses
// Notes:   Register A and B hold no reset value
package mtc_pkg;
  // ******************************
  // Register map (byte addresses)
  // ******************************
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_CMP_A  = 5'h04;
  localparam logic [4:0] ADDR_CAP_B  = 5'h08;
  localparam logic [4:0] ADDR_COUNT  = 5'h0c;
  localparam logic [4:0] ADDR_CFG    = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  // ******************************
  // Control register fields
  // ******************************
  localparam int MODE_LSB   = 0;
  localparam int MODE_W     = 3;
  localparam int CKSEL_LSB  = 3;
  localparam int CKSEL_W    = 2;
  localparam int START_BIT  = 5;
  localparam int CAP_BIT    = 6;
  localparam int FF_BIT     = 7;
  localparam int CTRL_W     = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  // ******************************
  // Config and status fields
  // ******************************
  localparam int CFG_EDGE_BIT  = 0;
  localparam int CFG_DIVSRC_BIT = 1;
  localparam int CFG_SLOW_BIT  = 2;
  localparam int CFG_PPG_EDGE_BIT = 3;
  localparam int CFG_W         = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
  localparam int ST_RUN_BIT  = 0;
  localparam int ST_WAIT_BIT = 1;
  localparam int ST_FF_BIT   = 2;
  localparam int ST_PIN_BIT  = 3;
  // ******************************
  // Operating modes
  // ******************************
  localparam logic [MODE_W-1:0] MODE_TIMER  = 3'h0;
  localparam logic [MODE_W-1:0] MODE_EXTTRG = 3'h1;
  localparam logic [MODE_W-1:0] MODE_EVENT  = 3'h2;
  localparam logic [MODE_W-1:0] MODE_WINDOW = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PWM    = 3'h4;
  localparam logic [MODE_W-1:0] MODE_PPG    = 3'h5;
  // ******************************
  // Count clock selects and dividers
  // ******************************
  localparam logic [CKSEL_W-1:0] CK_DIV8   = 2'h0;
  localparam logic [CKSEL_W-1:0] CK_DIV128 = 2'h1;
  localparam logic [CKSEL_W-1:0] CK_DIV2K  = 2'h2;
  localparam int PRE_W    = 11;
  localparam int FC_SH_8  = 3;
  localparam int FC_SH_128 = 7;
  localparam int FC_SH_2K = 11;
  localparam int FS_SH_8  = 3;
  // ******************************
  // Input noise rejection, in high_freq_clock periods
  // ******************************
  localparam int NOISE_REJECT_CYC = 7;
  localparam int DETECT_MIN_CYC   = 24;
  localparam int FILT_LEN         = NOISE_REJECT_CYC + 1;
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } mtc_state_t;
endpackage

// File: rtl/mtc_edge_if.sv
// Purpose: Conditioned pulse input between filter and core
// Assumes: Single clock domain
// Notes:   Edges are one-cycle pulses
interface mtc_edge_if;
  logic slow_mode;
  logic level;
  logic rise;
  logic fall;
  modport filt (input slow_mode, output level, output rise, output fall);
  modport core (output slow_mode, input level, input rise, input fall);
endinterface

// File: rtl/mtc_input_filter.sv
// Purpose: Synchronise and deglitch the pulse input pin
// Assumes: high_freq_clock is the system clock
// Notes:   Filter is bypassed in slow mode
module mtc_input_filter #(
  parameter int FLEN = mtc_pkg::FILT_LEN
) (
  input  wire logic  clk_in,
  input  wire logic  rst_b_in,
  input  wire logic  pin_in,
  mtc_edge_if.filt   edge_if
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic       level_reg;
  logic       prev_reg;
  logic [4:0] cnt_reg;

  // Two-flop synchroniser, first stage read only by the second
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Outside slow mode a new level is accepted only after FLEN stable
  // cycles, so pulses of NOISE_REJECT_CYC or less never pass
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_reg <= 1'b0;
      cnt_reg   <= 5'h00;
    end else if (sync2_reg == level_reg) begin
      cnt_reg <= 5'h00;
    end else if (edge_if.slow_mode || cnt_reg == 5'(FLEN - 1)) begin
      level_reg <= sync2_reg;
      cnt_reg   <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_reg;
    end
  end

  assign edge_if.level = level_reg;
  assign edge_if.rise  = level_reg & ~prev_reg;
  assign edge_if.fall  = ~level_reg & prev_reg;
endmodule // mtc_input_filter

// File: testbench/mtc_timer_sva.sv
// Purpose: Port-level assertions for the multimode timer/counter
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module, sees its ports only
module mtc_timer_sva (
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_B_IN,
  input wire logic [4:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0]  AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic        PULSE_INPUT_PIN_IN,
  input wire logic        LOW_FREQ_TICK_IN,
  input wire logic        PULSE_GENERATOR_OUTPUT_OUT,
  input wire logic        TIMER_MATCH_INTERRUPT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic wq;
  logic irq;
  logic pulse_generator_output;
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  assign wq  = AVS_WAITREQUEST_OUT;
  assign irq = TIMER_MATCH_INTERRUPT_OUT;
  assign pulse_generator_output = PULSE_GENERATOR_OUTPUT_OUT;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // ********************
  // Bus and event checks
  // ********************
  wait_once_a: assert property (req && wq |=> !wq)
    else $error("bus stall longer than one cycle");
  stall_first_a: assert property ($rose(req) |-> wq)
    else $error("request answered without a stall");
  wait_idle_a: assert property (!req |-> !wq)
    else $error("stall with no request");
  rdata_hold_a: assert property (!(AVS_READ_IN && wq) |=> $stable(AVS_READDATA_OUT))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (AVS_READ_IN && !wq && AVS_ADDRESS_IN > 5'h14 |-> AVS_READDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (AVS_READ_IN && !wq |-> AVS_READDATA_OUT[31:16] == 16'h0)
    else $error("upper read bits not zero");
  irq_spacing_a: assert property ($rose(irq) |=> !irq [*7])
    else $error("interrupt pulse too long or too close");
  reset_quiet_a: assert property ($rose(RST_B_IN) |-> !pulse_generator_output && !irq)
    else $error("output or interrupt set out of reset");
  status_ff_a: assert property (AVS_READ_IN && wq && AVS_ADDRESS_IN == mtc_pkg::ADDR_STATUS
    |=> AVS_READDATA_OUT[mtc_pkg::ST_FF_BIT] == $past(pulse_generator_output))
    else $error("status flip-flop bit differs from output");
  cover property ($rose(irq));
  cover property ($fell(pulse_generator_output));
  cover property (AVS_READ_IN && !wq && AVS_ADDRESS_IN == mtc_pkg::ADDR_CAP_B);
endmodule // mtc_timer_sva

bind mtc_timer mtc_timer_sva u_sva (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_B_IN(RST_B_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
  .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PULSE_INPUT_PIN_IN(PULSE_INPUT_PIN_IN),
  .LOW_FREQ_TICK_IN(LOW_FREQ_TICK_IN), .PULSE_GENERATOR_OUTPUT_OUT(PULSE_GENERATOR_OUTPUT_OUT),
  .TIMER_MATCH_INTERRUPT_OUT(TIMER_MATCH_INTERRUPT_OUT)
);

// File: testbench/mtc_pulse_src.sv
// Purpose: Far side: pulse source on the input pin, load on the output
// Assumes: Levels change just after a rising clock edge
// Notes:   Level lengths counted in system clock cycles
module mtc_pulse_src (
  input  wire logic clk_in,
  input  wire logic ppg_in,
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  int   run_len = 0;
  int   hi_len = 0;
  int   lo_len = 0;
  initial pin_out = 1'b0;
  // Callers keep levels long and edges sparse, glitches only on purpose
  task automatic hold(input logic lvl, input int cyc);
    @(posedge clk_in);
    pin_out <= lvl;
    repeat (cyc - 1) @(posedge clk_in);
  endtask
  task automatic pulse(input logic lvl, input int w, input int gap);
    hold(lvl, w);
    hold(!lvl, gap);
  endtask
  // Load side: length of each finished output level
  always @(posedge clk_in) begin
    if (ppg_in !== last) begin
      if (last) begin
        hi_len = run_len;
      end else begin
        lo_len = run_len;
      end
      run_len = 1;
      last = ppg_in;
    end else begin
      run_len++;
    end
  end
endmodule // mtc_pulse_src

// File: testbench/mtc_timer_test.sv
// Purpose: Self-checking bench for the multimode timer/counter
// Assumes: 50 MHz clock, Avalon-MM master tasks
// Notes:   Reset pulses zero the counter but keep registers A and B
module mtc_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [1:0]  tcnt = 2'h0;
  logic        tick = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [31:0] b;
  logic        wq;
  logic        pin;
  logic        pulse_generator_output;
  logic        irq;
  int          miscompares = 0;
  int          checks_done = 0;
  int          irq_cnt = 0;
  int          cyc = 0;
  int          irq_t[$];
  int          a_val;
  int          n0;
  int          div[5] = '{8, 128, 2048, 32, 32};
  logic [3:0]  cfg[5] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h4};
  logic [1:0]  ck[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      irq_t.push_back(cyc);
    end
  end

  mtc_timer DUT (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq), .PULSE_INPUT_PIN_IN(pin),
    .LOW_FREQ_TICK_IN(tick), .PULSE_GENERATOR_OUTPUT_OUT(pulse_generator_output), .TIMER_MATCH_INTERRUPT_OUT(irq)
  );
  mtc_pulse_src src (.clk_in(clk), .ppg_in(pulse_generator_output), .pin_out(pin));

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] k, input logic s,
                                      input logic c, input logic f);
    return {24'h0, f, c, s, k, m};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) timeout();
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(v, e);
  endtask
  task automatic wait_cnt(input int tgt, input int lim);
    int t;
    for (t = 0; t < lim && irq_cnt < tgt; t++) @(posedge clk);
    if (irq_cnt < tgt) timeout();
  endtask
  // Cheapest way to zero the counter: registers A and B survive it
  task automatic restart();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  initial begin
    a_val = $urandom(32'h4e67);
    a_val = 1 + ($urandom % 4);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rchk(mtc_pkg::ADDR_CTRL, {24'h0, mtc_pkg::CTRL_RESET});
    check({31'h0, pulse_generator_output}, 32'h0);
    rchk(5'h18, 32'h0);
    bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'h1234);
    bus(1'b1, mtc_pkg::ADDR_CTRL, {29'h0, mtc_pkg::MODE_PPG});
    bus(1'b1, mtc_pkg::ADDR_CAP_B, 32'h0055);
    bus(1'b1, mtc_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, mtc_pkg::ADDR_CAP_B, 32'h00aa);
    rchk(mtc_pkg::ADDR_CAP_B, 32'h0055);
    restart();
    rchk(mtc_pkg::ADDR_CMP_A, 32'h1234);
    rchk(mtc_pkg::ADDR_CAP_B, 32'h0055);
    for (int i = 0; i < 5; i++) begin
      restart();
      bus(1'b1, mtc_pkg::ADDR_CFG, {28'h0, cfg[i]});
      bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'(a_val));
      bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_TIMER, ck[i], 1'b1, 1'b0, 1'b0));
      irq_t.delete();
      wait_cnt(irq_cnt + 3, 4 * (a_val + 1) * div[i] + 200);
      check(32'(irq_t[2] - irq_t[1]), 32'((a_val + 1) * div[i]));
    end
    restart();
    bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'hffff);
    bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_TIMER, 2'h0, 1'b1, 1'b0, 1'b0));
    repeat (40) @(posedge clk);
    bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_TIMER, 2'h0, 1'b1, 1'b1, 1'b0));
    bus(1'b0, mtc_pkg::ADDR_CAP_B, 32'h0);
    b = v;
    bus(1'b0, mtc_pkg::ADDR_COUNT, 32'h0);
    check({31'h0, (v - b) < 32'h2}, 32'h1);
    rchk(mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_TIMER, 2'h0, 1'b1, 1'b0, 1'b0));
    restart();
    bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'h3);
    bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_EVENT, 2'h0, 1'b1, 1'b0, 1'b0));
    n0 = irq_cnt;
    repeat (2) src.pulse(1'b1, 30, 30);
    rchk(mtc_pkg::ADDR_COUNT, 32'h2);
    src.pulse(1'b1, 5, 30);
    rchk(mtc_pkg::ADDR_COUNT, 32'h2);
    repeat (2) src.pulse(1'b1, 30, 30);
    check(32'(irq_cnt - n0), 32'h1);
    rchk(mtc_pkg::ADDR_COUNT, 32'h0);
    restart();
    bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_EXTTRG, 2'h0, 1'b1, 1'b0, 1'b0));
    n0 = irq_cnt;
    repeat (60) @(posedge clk);
    rchk(mtc_pkg::ADDR_COUNT, 32'h0);
    src.pulse(1'b1, 30, 60);
    check(32'(irq_cnt - n0), 32'h1);
    rchk(mtc_pkg::ADDR_COUNT, 32'h0);
    src.pulse(1'b1, 30, 60);
    check(32'(irq_cnt - n0), 32'h2);
    for (int c = 0; c < 2; c++) begin
      restart();
      bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'hffff);
      bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_PWM, 2'h0, 1'b1, 1'(c), 1'b0));
      n0 = irq_cnt;
      src.pulse(1'b1, 80, 40);
      // First capture must be read before the next start edge
      if (c == 1) begin
        bus(1'b0, mtc_pkg::ADDR_CAP_B, 32'h0);
        check({31'h0, v >= 32'h9 && v <= 32'hb}, 32'h1);
        src.hold(1'b1, 30);
      end
      check(32'(irq_cnt - n0), 32'h1);
      bus(1'b0, mtc_pkg::ADDR_CAP_B, 32'h0);
      check({31'h0, v >= 32'(9 + 5 * c) && v <= 32'(11 + 5 * c)}, 32'h1);
      if (c == 0) rchk(mtc_pkg::ADDR_COUNT, 32'h0);
      src.hold(1'b0, 30);
    end
    // Active-low window: pin high holds the count
    restart();
    bus(1'b1, mtc_pkg::ADDR_CFG, 32'h1);
    bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'hffff);
    src.hold(1'b1, 40);
    bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_WINDOW, 2'h0, 1'b1, 1'b0, 1'b0));
    src.hold(1'b1, 80);
    rchk(mtc_pkg::ADDR_COUNT, 32'h0);
    src.hold(1'b0, 80);
    bus(1'b0, mtc_pkg::ADDR_COUNT, 32'h0);
    check({31'h0, v >= 32'h7 && v <= 32'ha}, 32'h1);
    for (int f = 0; f < 2; f++) begin
      restart();
      bus(1'b1, mtc_pkg::ADDR_CMP_A, 32'h14);
      bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_PPG, 2'h0, 1'b0, 1'b0, 1'(f)));
      @(negedge clk);
      check({31'h0, pulse_generator_output}, 32'(f));
      bus(1'b0, mtc_pkg::ADDR_STATUS, 32'h0);
      check({31'h0, v[mtc_pkg::ST_FF_BIT]}, 32'(f));
      bus(1'b1, mtc_pkg::ADDR_CAP_B, 32'h5);
      bus(1'b1, mtc_pkg::ADDR_CTRL, ctl(mtc_pkg::MODE_PPG, 2'h0, 1'b1, 1'b0, 1'(f)));
      wait_cnt(irq_cnt + 3, 800);
      check(32'(f ? src.lo_len : src.hi_len), 32'h78);
    end
    report_and_stop();
  end
endmodule // mtc_timer_test
